// [rtl/rtq_pkg.sv]
// Purpose: Shared constants and state type for the RTC interrupt combiner
// Assumes: 40 MHz system clock; 8-bit register port with 4-bit address
// Notes:   Register offsets, field positions and pulse timing live here

package rtq_pkg;

  // System clock rate
  localparam int unsigned CLK_HZ = 40000000;

  // Pulse widths as divisors of one second (width = 1/DIV s)
  localparam int unsigned DIV_8192 = 8192;
  localparam int unsigned DIV_4096 = 4096;
  localparam int unsigned DIV_128  = 128;
  localparam int unsigned DIV_64   = 64;

  // Widths in clock cycles, rounded down
  localparam int unsigned CYC_8192 = CLK_HZ / DIV_8192;
  localparam int unsigned CYC_4096 = CLK_HZ / DIV_4096;
  localparam int unsigned CYC_128  = CLK_HZ / DIV_128;
  localparam int unsigned CYC_64   = CLK_HZ / DIV_64;

  // Pulse counter width
  localparam int unsigned CNT_W = 20;

  // Register offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_CTRL2  = 4'h1;
  localparam logic [3:0] OFS_FLAGS  = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;

  // Flag register bit positions
  localparam int unsigned FB_TICK  = 0;
  localparam int unsigned FB_CD    = 1;
  localparam int unsigned FB_ALARM = 2;
  localparam int unsigned FB_TS0   = 3;
  localparam int unsigned FB_TS1   = 4;
  localparam int unsigned FB_BSW   = 5;
  localparam int unsigned FB_WD    = 6;
  localparam int unsigned FB_BLOW  = 7;

  // Countdown source clock selection codes
  localparam logic [1:0] SRC_4096 = 2'h0;
  localparam logic [1:0] SRC_64   = 2'h1;
  localparam logic [1:0] SRC_1    = 2'h2;
  localparam logic [1:0] SRC_1_60 = 2'h3;

  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [2:0] CTRL2_RST = 3'h0;

  // Whole state of the block
  typedef struct packed {
    logic             sec_enable;
    logic             slow_tick_enable;
    logic             timer_pulse_select;
    logic             countdown_irq_enable;
    logic             alarm_irq_enable;
    logic             timestamp_irq_enable;
    logic             switchover_irq_enable;
    logic             battery_low_irq_enable;
    logic [1:0]       watchdog_control_field;
    logic             switchover_stamp_enable;
    logic             tick_flag;
    logic             countdown_flag;
    logic             alarm_flag;
    logic [1:0]       timestamp_flags;
    logic             battery_switch_flag;
    logic             battery_low_flag;
    logic             ts_pin_prev;
    logic [CNT_W-1:0] tick_cnt;
    logic [CNT_W-1:0] cd_cnt;
    logic             irq_oe;
    logic             irq_level;
    logic             stamp_capture;
    logic [7:0]       rdata;
  } rtq_state_t;

endpackage

// [rtl/rtq_irq.sv]
// Purpose: RTC interrupt combiner with switch-over timestamp control
// Assumes: All inputs synchronous to clk; event inputs are one-cycle strobes
// Notes:   Interrupt pin is open-drain, active low: irq_n_o is always 0, irq_n_oe pulls
//
// Notes on behaviour
// - Stamp enable 0: switch-over never touches the timestamp registers.
// - Stamp enable 1, switch flag 0: switch-over captures time, sets switch flag.
// - Stamp enable 1, switch flag 1: no capture, switch-over and pin edges ignored.
// - Interrupt pin active low open-drain, released when all sources disabled.
// - Sources other than tick and countdown drive a level following their flag.
// - Tick output is pulse if pulse select 1, else level until flag cleared.
// - Tick, countdown, alarm, timestamp, switch flags clearable; watchdog, battery low not.
// - Battery low flag clears itself when the battery is replaced.
// - Tick flag: never, per minute, or per second depending on the two enables.
// - Tick pulse is one sixty-fourth of a second long.
// - Countdown output is pulse per period or level, chosen by pulse select.
// - Countdown pulse width depends on source clock and loaded value n.
// - Countdown gives no interrupts while loaded value is zero.
// - Clearing tick or countdown flag ends its pulse at once.
// - Watchdog field enables a level interrupt following the watchdog flag.
// - Watchdog interrupt ends when the watchdog clears its own flag or the field is set to 0.
// - Alarm interrupt follows alarm flag, ends at once when cleared.
// - Timestamp interrupt follows timestamp flags, ends at once when cleared.
// - Switch-over interrupt follows switch flag, ends at once when cleared.
// - Battery low interrupt follows its flag, ends on replacement or disable.
//
// Added by the designer: strobed register access and the register offsets.

`timescale 1ns/1ps

module rtq_irq #(
  parameter int unsigned TICK_PULSE_CYC = rtq_pkg::CYC_64,
  parameter int unsigned CD_8192_CYC    = rtq_pkg::CYC_8192,
  parameter int unsigned CD_4096_CYC    = rtq_pkg::CYC_4096,
  parameter int unsigned CD_128_CYC     = rtq_pkg::CYC_128,
  parameter int unsigned CD_64_CYC      = rtq_pkg::CYC_64
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       sec_inc,
  input  wire logic       min_inc,
  input  wire logic       cd_period,
  input  wire logic [1:0] cd_src_sel,
  input  wire logic [7:0] cd_value,
  input  wire logic       alarm_match,
  input  wire logic       timestamp_trigger_n,
  input  wire logic       switchover_event,
  input  wire logic       watchdog_flag,
  input  wire logic       batt_low_detect,
  input  wire logic       batt_replaced,
  output logic      [1:0] watchdog_control_field,
  output logic            stamp_capture,
  output logic            irq_n_o,
  output logic            irq_n_oe
);

  localparam int unsigned CNT_MAX = (1 << rtq_pkg::CNT_W) - 1;

  // Refuse widths the pulse counters cannot hold, one check per width
  if (TICK_PULSE_CYC < 1 || TICK_PULSE_CYC > CNT_MAX) begin : g_bad_tick
    $error("tick pulse width out of counter range");
  end
  if (CD_8192_CYC < 1 || CD_8192_CYC > CNT_MAX) begin : g_bad_cd8192
    $error("short fast countdown pulse width out of counter range");
  end
  if (CD_4096_CYC < 1 || CD_4096_CYC > CNT_MAX) begin : g_bad_cd4096
    $error("fast countdown pulse width out of counter range");
  end
  if (CD_128_CYC < 1 || CD_128_CYC > CNT_MAX) begin : g_bad_cd128
    $error("short slow countdown pulse width out of counter range");
  end
  if (CD_64_CYC < 1 || CD_64_CYC > CNT_MAX) begin : g_bad_cd64
    $error("slow countdown pulse width out of counter range");
  end

  rtq_pkg::rtq_state_t s_q;
  rtq_pkg::rtq_state_t s_d;

  // Next-state logic
  always_comb begin
    logic                     wr_ctrl;
    logic                     wr_ctrl2;
    logic                     wr_flags;
    logic                     ts_fall;
    logic                     stamp_block;
    logic                     tick_set;
    logic                     cd_set;
    logic                     clr_tick;
    logic                     clr_cd;
    logic [rtq_pkg::CNT_W-1:0] cd_width;
    logic                     tick_req;
    logic                     cd_req;
    logic                     any_req;
    logic [7:0]               flags_rd;
    logic                     set_alarm;
    logic                     set_ts0;
    logic                     set_ts1;
    logic                     set_bsw;
    logic                     clr_alarm;
    logic                     clr_ts0;
    logic                     clr_ts1;
    logic                     clr_bsw;
    logic                     wd_req;
    logic                     alarm_req;
    logic                     ts_req;
    logic                     bsw_req;
    logic                     blow_req;
    // Locals start from known values on every pass
    ts_fall     = 1'b0;
    stamp_block = 1'b0;
    tick_set    = 1'b0;
    cd_set      = 1'b0;
    clr_tick    = 1'b0;
    clr_cd      = 1'b0;
    cd_width    = '0;
    tick_req    = 1'b0;
    cd_req      = 1'b0;
    any_req     = 1'b0;
    flags_rd    = 8'h00;
    set_alarm   = 1'b0;
    set_ts0     = 1'b0;
    set_ts1     = 1'b0;
    set_bsw     = 1'b0;
    clr_alarm   = 1'b0;
    clr_ts0     = 1'b0;
    clr_ts1     = 1'b0;
    clr_bsw     = 1'b0;
    wd_req      = 1'b0;
    alarm_req   = 1'b0;
    ts_req      = 1'b0;
    bsw_req     = 1'b0;
    blow_req    = 1'b0;
    wr_ctrl     = reg_wr && (reg_addr == rtq_pkg::OFS_CTRL);
    wr_ctrl2    = reg_wr && (reg_addr == rtq_pkg::OFS_CTRL2);
    wr_flags    = reg_wr && (reg_addr == rtq_pkg::OFS_FLAGS);
    s_d         = s_q;

    // Control registers
    if (wr_ctrl) begin
      s_d.sec_enable             = reg_wdata[0];
      s_d.slow_tick_enable       = reg_wdata[1];
      s_d.timer_pulse_select     = reg_wdata[2];
      s_d.countdown_irq_enable   = reg_wdata[3];
      s_d.alarm_irq_enable       = reg_wdata[4];
      s_d.timestamp_irq_enable   = reg_wdata[5];
      s_d.switchover_irq_enable  = reg_wdata[6];
      s_d.battery_low_irq_enable = reg_wdata[7];
    end
    if (wr_ctrl2) begin
      s_d.watchdog_control_field  = reg_wdata[1:0];
      s_d.switchover_stamp_enable = reg_wdata[2];
    end

    // Timestamp pin edge and switch-over capture
    ts_fall           = s_q.ts_pin_prev && !timestamp_trigger_n;
    s_d.ts_pin_prev   = timestamp_trigger_n;
    stamp_block       = s_q.switchover_stamp_enable && s_q.battery_switch_flag;
    set_ts0           = ts_fall && !stamp_block;
    set_ts1           = switchover_event && s_q.switchover_stamp_enable &&
                        !s_q.battery_switch_flag;
    // Switch flag rises on every switch-over unless stamping has locked it
    set_bsw           = switchover_event && !stamp_block;
    s_d.stamp_capture = set_ts0 || set_ts1;

    // Event sources; a write of 0 to a flag bit clears it, set wins
    tick_set  = s_q.sec_enable ? sec_inc : (s_q.slow_tick_enable && min_inc);
    cd_set    = cd_period && (cd_value != 8'h00);
    set_alarm = alarm_match;
    clr_tick  = wr_flags && !reg_wdata[rtq_pkg::FB_TICK];
    clr_cd    = wr_flags && !reg_wdata[rtq_pkg::FB_CD];
    clr_alarm = wr_flags && !reg_wdata[rtq_pkg::FB_ALARM];
    clr_ts0   = wr_flags && !reg_wdata[rtq_pkg::FB_TS0];
    clr_ts1   = wr_flags && !reg_wdata[rtq_pkg::FB_TS1];
    clr_bsw   = wr_flags && !reg_wdata[rtq_pkg::FB_BSW];

    // Clearable flags
    s_d.tick_flag           = (s_q.tick_flag && !clr_tick) || tick_set;
    s_d.countdown_flag      = (s_q.countdown_flag && !clr_cd) || cd_set;
    s_d.alarm_flag          = (s_q.alarm_flag && !clr_alarm) || set_alarm;
    s_d.timestamp_flags[0]  = (s_q.timestamp_flags[0] && !clr_ts0) || set_ts0;
    s_d.timestamp_flags[1]  = (s_q.timestamp_flags[1] && !clr_ts1) || set_ts1;
    s_d.battery_switch_flag = (s_q.battery_switch_flag && !clr_bsw) || set_bsw;
    // Battery low flag is not writable; replacement clears it
    if (batt_low_detect) begin
      s_d.battery_low_flag = 1'b1;
    end else if (batt_replaced) begin
      s_d.battery_low_flag = 1'b0;
    end

    // Tick pulse generator, 1/64 s
    if (tick_set && s_q.timer_pulse_select) begin
      s_d.tick_cnt = rtq_pkg::CNT_W'(TICK_PULSE_CYC);
    end else if (!s_d.tick_flag) begin
      s_d.tick_cnt = '0;
    end else if (s_q.tick_cnt != '0) begin
      s_d.tick_cnt = s_q.tick_cnt - 1'b1;
    end

    // Countdown pulse width from source clock and loaded value
    unique case (cd_src_sel)
      rtq_pkg::SRC_4096: begin
        cd_width = (cd_value == 8'h01) ? rtq_pkg::CNT_W'(CD_8192_CYC)
                                       : rtq_pkg::CNT_W'(CD_4096_CYC);
      end
      rtq_pkg::SRC_64: begin
        cd_width = (cd_value == 8'h01) ? rtq_pkg::CNT_W'(CD_128_CYC)
                                       : rtq_pkg::CNT_W'(CD_64_CYC);
      end
      rtq_pkg::SRC_1, rtq_pkg::SRC_1_60: begin
        cd_width = rtq_pkg::CNT_W'(CD_64_CYC);
      end
    endcase

    // Countdown pulse generator
    if (cd_set && s_q.timer_pulse_select) begin
      s_d.cd_cnt = cd_width;
    end else if (!s_d.countdown_flag) begin
      s_d.cd_cnt = '0;
    end else if (s_q.cd_cnt != '0) begin
      s_d.cd_cnt = s_q.cd_cnt - 1'b1;
    end

    // Per-source requests, pulsed or level
    tick_req = (s_q.sec_enable || s_q.slow_tick_enable) &&
               (s_q.timer_pulse_select ? (s_d.tick_cnt != '0) : s_d.tick_flag);
    cd_req   = s_q.countdown_irq_enable &&
               (s_q.timer_pulse_select ? (s_d.cd_cnt != '0) : s_d.countdown_flag);
    // Level sources follow their flags
    wd_req    = (s_q.watchdog_control_field != 2'h0) && watchdog_flag;
    alarm_req = s_q.alarm_irq_enable && s_d.alarm_flag;
    ts_req    = s_q.timestamp_irq_enable && (s_d.timestamp_flags != 2'h0);
    bsw_req   = s_q.switchover_irq_enable && s_d.battery_switch_flag;
    blow_req  = s_q.battery_low_irq_enable && s_d.battery_low_flag;
    any_req   = tick_req || cd_req || wd_req || alarm_req ||
                ts_req || bsw_req || blow_req;
    s_d.irq_oe    = any_req;
    s_d.irq_level = 1'b0;

    // Read port, data valid only in the cycle after the strobe
    flags_rd = {s_q.battery_low_flag, watchdog_flag, s_q.battery_switch_flag,
                s_q.timestamp_flags, s_q.alarm_flag, s_q.countdown_flag, s_q.tick_flag};
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        rtq_pkg::OFS_CTRL: begin
          s_d.rdata = {s_q.battery_low_irq_enable, s_q.switchover_irq_enable,
                       s_q.timestamp_irq_enable, s_q.alarm_irq_enable,
                       s_q.countdown_irq_enable, s_q.timer_pulse_select,
                       s_q.slow_tick_enable, s_q.sec_enable};
        end
        rtq_pkg::OFS_CTRL2: begin
          s_d.rdata = {5'h00, s_q.switchover_stamp_enable, s_q.watchdog_control_field};
        end
        rtq_pkg::OFS_FLAGS: begin
          s_d.rdata = flags_rd;
        end
        rtq_pkg::OFS_STATUS: begin
          s_d.rdata = {5'h00, (s_q.cd_cnt != '0), (s_q.tick_cnt != '0), s_q.irq_oe};
        end
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q                         <= '0;
      {s_q.battery_low_irq_enable, s_q.switchover_irq_enable,
       s_q.timestamp_irq_enable, s_q.alarm_irq_enable,
       s_q.countdown_irq_enable, s_q.timer_pulse_select,
       s_q.slow_tick_enable, s_q.sec_enable} <= rtq_pkg::CTRL_RST;
      {s_q.switchover_stamp_enable, s_q.watchdog_control_field} <= rtq_pkg::CTRL2_RST;
      s_q.battery_switch_flag     <= 1'b0;
      s_q.ts_pin_prev             <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state
  assign reg_rdata              = s_q.rdata;
  assign watchdog_control_field = s_q.watchdog_control_field;
  assign stamp_capture          = s_q.stamp_capture;
  assign irq_n_o                = s_q.irq_level;
  assign irq_n_oe               = s_q.irq_oe;

endmodule

// [verification/rtq_irq_chk.sv]
// Purpose: Concurrent checks on the interrupt combiner ports
// Assumes: Bus writes mirror enables and the switch flag exactly
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
module rtq_irq_chk (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       alarm_match,
  input wire logic       timestamp_trigger_n,
  input wire logic       switchover_event,
  input wire logic       watchdog_flag,
  input wire logic [1:0] watchdog_control_field,
  input wire logic       stamp_capture,
  input wire logic       irq_n_o,
  input wire logic       irq_n_oe
);
  logic [7:0] ctrl_q;
  logic       stamp_en_q;
  logic       switch_q;
  // Shadow of enables and switch flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q     <= 8'h00;
      stamp_en_q <= 1'b0;
      switch_q   <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == rtq_pkg::OFS_CTRL)
        ctrl_q <= reg_wdata;
      if (reg_wr && reg_addr == rtq_pkg::OFS_CTRL2)
        stamp_en_q <= reg_wdata[2];
      if (switchover_event && !(stamp_en_q && switch_q))
        switch_q <= 1'b1;
      else if (reg_wr && reg_addr == rtq_pkg::OFS_FLAGS && !reg_wdata[rtq_pkg::FB_BSW])
        switch_q <= 1'b0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_odrain_data: assert property (irq_n_o == 1'b0)
    else $error("interrupt data driven high");
  a_all_quiet: assert property (
    ctrl_q == 8'h00 && $past(ctrl_q) == 8'h00 && watchdog_control_field == 2'h0
    && $past(watchdog_control_field) == 2'h0 |-> !irq_n_oe)
    else $error("pin pulled with every source disabled");
  a_wd_level: assert property (
    $past(watchdog_control_field) != 2'h0 && $past(watchdog_flag) |-> irq_n_oe)
    else $error("watchdog interrupt missing");
  a_stamp_taken: assert property (
    switchover_event && stamp_en_q && !switch_q |=> stamp_capture)
    else $error("switch-over not captured");
  a_stamp_off: assert property (
    switchover_event && !stamp_en_q && $stable(timestamp_trigger_n) |=> !stamp_capture)
    else $error("capture with stamping disabled");
  a_stamp_held: assert property (stamp_en_q && switch_q |=> !stamp_capture)
    else $error("capture while switch flag set");
  a_switch_irq: assert property (
    ctrl_q[6] && $past(ctrl_q[6]) && switch_q |-> irq_n_oe)
    else $error("switch-over interrupt missing");
  a_alarm_irq: assert property (
    ctrl_q[4] && $past(ctrl_q[4]) && $past(alarm_match) |-> irq_n_oe)
    else $error("alarm interrupt missing");
  c_capture: cover property (stamp_capture);
  c_irq_rise: cover property ($rose(irq_n_oe));
  c_wd_irq: cover property (watchdog_flag && irq_n_oe);
endmodule

// [verification/rtq_host_model.sv]
// Purpose: Host side of the open-drain interrupt pin
// Assumes: Board pull-up on the line
// Notes:   A released pin reads high
`timescale 1ns/1ps
module rtq_host_model (
  input  wire logic irq_n_o,
  input  wire logic irq_n_oe,
  output logic      irq_line
);
  // Pull-up wins whenever the device lets go
  assign irq_line = irq_n_oe ? irq_n_o : 1'b1;
endmodule

// [verification/rtq_irq_bench.sv]
// Purpose: Self-checking bench for the interrupt combiner
// Assumes: Short pulse parameters, 40 MHz clock
// Notes:   Events travel on one vector, one bit per source
`timescale 1ns/1ps
module rtq_irq_bench;
  localparam int TP = 32, C8K = 4, C4K = 6, C128 = 16, C64 = 32;
  localparam logic [3:0] A_CTRL = rtq_pkg::OFS_CTRL, A_CTRL2 = rtq_pkg::OFS_CTRL2;
  localparam logic [3:0] A_FLAGS = rtq_pkg::OFS_FLAGS;
  logic       clk, rst_b, reg_wr, reg_rd, timestamp_trigger_n, watchdog_flag;
  logic       stamp_capture, irq_n_o, irq_n_oe, irq_line;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, cd_value;
  logic [6:0] ev;
  logic [1:0] cd_src_sel, wdc;
  int         fails, samples_checked, ncap, seed, r, i;
  rtq_irq #(.TICK_PULSE_CYC(TP), .CD_8192_CYC(C8K), .CD_4096_CYC(C4K), .CD_128_CYC(C128),
    .CD_64_CYC(C64)) dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sec_inc(ev[0]), .min_inc(ev[1]), .cd_period(ev[2]), .cd_src_sel, .cd_value,
    .alarm_match(ev[3]), .timestamp_trigger_n, .switchover_event(ev[4]), .watchdog_flag,
    .batt_low_detect(ev[5]), .batt_replaced(ev[6]), .watchdog_control_field(wdc),
    .stamp_capture, .irq_n_o, .irq_n_oe);
  rtq_host_model host (.irq_n_o, .irq_n_oe, .irq_line);
  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Count timestamp captures
  always @(posedge clk) if (stamp_capture === 1'b1) ncap <= ncap + 1;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    ev <= 7'h01 << k;
    @(posedge clk);
    ev <= 7'h00;
  endtask
  task automatic irq(input logic e);
    @(posedge clk);
    #1;
    chk("irq line", {7'h00, ~e}, {7'h00, irq_line});
  endtask
  task automatic ts_edge;
    @(posedge clk);
    timestamp_trigger_n <= 1'b0;
    @(posedge clk);
    timestamp_trigger_n <= 1'b1;
  endtask
  // Cycles the line is pulled after one event
  task automatic width(input int k, input int w);
    int c;
    c = 0;
    pulse(k);
    repeat (200) begin
      #1;
      if (irq_line === 1'b0) c++;
      @(posedge clk);
    end
    chk("pulse width", w[7:0], c[7:0]);
  endtask
  function automatic int cdw(input int s, input bit one);
    if (s == 0)
      return one ? C8K : C4K;
    if (s == 1)
      return one ? C128 : C64;
    return C64;
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog against hangs
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end
  // Main sequence
  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, ev, cd_src_sel, watchdog_flag} = '0;
    {fails, samples_checked, ncap} = '0;
    cd_value = 8'h01;
    timestamp_trigger_n = 1'b1;
    seed = 16245;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 5; i++) rd((i == 4) ? 4'hf : i[3:0], 8'h00, "reset value");
    $display("test reset finished");
    pulse(4);
    rd(A_FLAGS, 8'h20, "flags");
    chk("captures", 8'h00, ncap[7:0]);
    wr(A_FLAGS, 8'h00);
    wr(A_CTRL2, 8'h04);
    pulse(4);
    rd(A_FLAGS, 8'h30, "flags");
    chk("captures", 8'h01, ncap[7:0]);
    pulse(4);
    ts_edge();
    rd(A_FLAGS, 8'h30, "flags");
    chk("captures", 8'h01, ncap[7:0]);
    wr(A_CTRL, 8'h40);
    irq(1'b1);
    wr(A_FLAGS, 8'h00);
    irq(1'b0);
    wr(A_CTRL, 8'h20);
    ts_edge();
    irq(1'b1);
    rd(A_FLAGS, 8'h08, "flags");
    wr(A_FLAGS, 8'h00);
    irq(1'b0);
    $display("test switch-over finished");
    for (i = 0; i < 4; i++) begin
      wr(A_CTRL, i[7:0]);
      pulse(0);
      rd(A_FLAGS, {7'h00, i[0]}, "tick flag");
      wr(A_FLAGS, 8'h00);
      pulse(1);
      if (i < 3) rd(A_FLAGS, {7'h00, i == 2}, "tick flag");
      wr(A_FLAGS, 8'h00);
    end
    wr(A_CTRL, 8'h01);
    pulse(0);
    repeat (40) @(posedge clk);
    irq(1'b1);
    wr(A_FLAGS, 8'h00);
    irq(1'b0);
    wr(A_CTRL, 8'h05);
    width(0, TP);
    wr(A_FLAGS, 8'h00);
    pulse(0);
    rd(rtq_pkg::OFS_STATUS, 8'h03, "status");
    wr(A_FLAGS, 8'h00);
    irq(1'b0);
    $display("test tick finished");
    wr(A_CTRL, 8'h0c);
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      cd_src_sel <= i[2:1];
      cd_value <= i[0] ? 8'h01 : 8'h02 + {2'h0, r[5:0]};
      width(2, cdw(i / 2, i[0]));
      wr(A_FLAGS, 8'h00);
    end
    wr(A_CTRL, 8'h08);
    pulse(2);
    repeat (40) @(posedge clk);
    irq(1'b1);
    wr(A_FLAGS, 8'h00);
    cd_value <= 8'h00;
    pulse(2);
    rd(A_FLAGS, 8'h00, "countdown flag");
    irq(1'b0);
    $display("test countdown finished");
    wr(A_CTRL, 8'h00);
    wr(A_CTRL2, 8'h01);
    #1;
    chk("watchdog field", 8'h01, {6'h00, wdc});
    @(posedge clk);
    watchdog_flag <= 1'b1;
    irq(1'b1);
    wr(A_FLAGS, 8'h00);
    rd(A_FLAGS, 8'h40, "flags");
    irq(1'b1);
    @(posedge clk);
    watchdog_flag <= 1'b0;
    irq(1'b0);
    wr(A_CTRL2, 8'h00);
    wr(A_CTRL, 8'h80);
    pulse(5);
    irq(1'b1);
    wr(A_FLAGS, 8'h00);
    rd(A_FLAGS, 8'h80, "flags");
    pulse(6);
    rd(A_FLAGS, 8'h00, "flags");
    irq(1'b0);
    pulse(5);
    wr(A_CTRL, 8'h00);
    irq(1'b0);
    wr(A_CTRL, 8'h10);
    repeat (4) begin
      r = $random(seed);
      pulse(3);
      irq(1'b1);
      wr(A_FLAGS, r[7:0] & 8'hfb);
      irq(1'b0);
    end
    $display("test level sources finished");
    complete_run();
  end
endmodule
bind rtq_irq rtq_irq_chk u_chk (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .alarm_match,
  .timestamp_trigger_n, .switchover_event, .watchdog_flag, .watchdog_control_field,
  .stamp_capture, .irq_n_o, .irq_n_oe);
